/* rtl/wdc_pkg.sv */
// constants and types for the two-stage watchdog control block
package wdc_pkg;
   localparam int unsigned CLK_HZ = 10_000_000;
   localparam int unsigned FAST_TICK_MS = 100;
   localparam int unsigned FAST_TICK_CYC = CLK_HZ / 1000 * FAST_TICK_MS;
   localparam int unsigned SLOW_PER_FAST = 10;
   localparam int unsigned DEFAULT_FIRST_MS = 10_000;
   localparam int unsigned DEFAULT_FINAL_S = 15;
   localparam logic [15:0] DEFAULT_FIRST_TICKS = 16'(DEFAULT_FIRST_MS / FAST_TICK_MS);
   localparam logic [15:0] DEFAULT_FINAL_TICKS = 16'(DEFAULT_FINAL_S);
   localparam logic [15:0] PERIOD_ALL_ONES = 16'hffff;

   // timer select codes
   localparam logic [1:0] SEL_NONE = 2'h0;
   localparam logic [1:0] SEL_FIRST = 2'h1;
   localparam logic [1:0] SEL_FINAL = 2'h2;

   // request codes: ascii w shifted by eight, or an index
   localparam logic [15:0] REQ_BASE = 16'h7700;
   localparam logic [15:0] START_REQUEST = REQ_BASE | 16'h0000;
   localparam logic [15:0] INHIBIT_REQUEST = REQ_BASE | 16'h0001;
   localparam logic [15:0] STATUS_QUERY_REQUEST = REQ_BASE | 16'h0002;

   // action mask bits
   localparam int unsigned FIRST_STAGE_MASK_BIT = 0;
   localparam int unsigned FINAL_STAGE_MASK_BIT = 1;
   localparam int unsigned THIRD_LEVEL_MASK_BIT = 2;

   // state vector codes
   localparam logic [7:0] ST_COUNTING_NO_ACTION = 8'h01;
   localparam logic [7:0] ST_EXPIRED = 8'h02;
   localparam logic [7:0] ST_RUNNING = 8'h04;
   localparam logic [7:0] ST_STOPPED = 8'h08;
   localparam logic [7:0] ST_SERVICED = 8'h10;

   // register byte offsets
   localparam logic [7:0] REG_REQUEST = 8'h00;
   localparam logic [7:0] REG_SELECT = 8'h04;
   localparam logic [7:0] REG_PERIOD = 8'h08;
   localparam logic [7:0] REG_CHAIN_PERIOD = 8'h0c;
   localparam logic [7:0] REG_CHAIN_TARGET = 8'h10;
   localparam logic [7:0] REG_ACTION_MASK = 8'h14;
   localparam logic [7:0] REG_STATE_VECTOR = 8'h18;
   localparam logic [7:0] REG_IRQ_STATUS = 8'h1c;
   localparam logic [7:0] REG_IRQ_MASK = 8'h20;

   // interrupt status bits
   localparam int unsigned EV_FIRST_EXPIRED = 0;
   localparam int unsigned EV_FINAL_EXPIRED = 1;
   localparam int unsigned EV_BAD_REQUEST = 2;
   localparam int unsigned NUM_EVENTS = 3;

   typedef enum logic [1:0] {
      WDC_STOPPED = 2'b00,
      WDC_RUNNING = 2'b01,
      WDC_NO_ACTION = 2'b11
   } wdc_mode_e;
endpackage : wdc_pkg

/* rtl/wdc_tick_gen.sv */
// tick enables: a fast tick and a slow tick every few fast ticks
`timescale 1ns/1ps
module wdc_tick_gen #(
   parameter int unsigned FAST_CYC = wdc_pkg::FAST_TICK_CYC,
   parameter int unsigned SLOW_DIV = wdc_pkg::SLOW_PER_FAST
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic resetn,
   // tick enables
   output logic tick_fast,
   output logic tick_slow
);
   import wdc_pkg::*;

   typedef struct packed {
      logic [31:0] cyc;
      logic [7:0] fast_cnt;
      logic fast;
      logic slow;
   } wdc_tick_s;

   wdc_tick_s s_r;
   wdc_tick_s s_nxt;

   always_comb begin
      s_nxt = s_r;
      s_nxt.fast = 1'b0;
      s_nxt.slow = 1'b0;
      if (s_r.cyc >= 32'(FAST_CYC - 1)) begin
         s_nxt.cyc = '0;
         s_nxt.fast = 1'b1;
         if (s_r.fast_cnt >= 8'(SLOW_DIV - 1)) begin
            s_nxt.fast_cnt = '0;
            s_nxt.slow = 1'b1;
         end else begin
            s_nxt.fast_cnt = s_r.fast_cnt + 8'h01;
         end
      end else begin
         s_nxt.cyc = s_r.cyc + 32'h1;
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign tick_fast = s_r.fast;
   assign tick_slow = s_r.slow;
endmodule : wdc_tick_gen

/* rtl/wdc_watchdog.sv */
// two-stage watchdog control: request decode, timers, state vector, registers
// Functional notes
// (RL1) select 1 first stage, 2 final stage
// (RL2) request codes: w<<8 or start/inhibit/status
// (RL3) requester supplies period 1 to 65534
// (RL4) period 0 or all ones takes default
// (RL5) chain target restarts timer on expiry
// (RL6) chained period follows same default substitution
// (RL7) set mask bit suppresses action, keeps counting
// (RL8) mask bits 0x1 first, 0x2 final
// (RL9) state vector: element 0 first, 1 final
// (RL10) stopped, running, no-action states are exclusive
// (RL11) running: first interrupts, final resets host
// (RL12) counting without action encoded 0x01
// (RL13) expired flag on first stage only
// (RL14) serviced flag 0x10, cleared when reported
// (RL15) second status query sees serviced cleared
// (RL16) first ticks 100 ms, final ticks 1 s
// (RL17) starting one restarts the other if active
// (RL18) first stage stoppable, final only restartable
// (RL19) reset: stopped, mask clear, flags clear
`timescale 1ns/1ps
module wdc_watchdog #(
   parameter int unsigned FAST_CYC = wdc_pkg::FAST_TICK_CYC
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic resetn,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // actions and interrupt
   output logic warn_irq,
   output logic host_reset,
   output logic irq
);
   import wdc_pkg::*;

   typedef struct packed {
      wdc_mode_e [1:0] mode;
      logic [1:0][15:0] cnt;
      logic [1:0][15:0] reload;
      logic [1:0][1:0] chain_tgt;
      logic [1:0][15:0] chain_per;
      logic expired;
      logic serviced;
      logic [1:0] sel;
      logic [15:0] period;
      logic [15:0] chain_period;
      logic [1:0] chain_target;
      logic [2:0] action_mask;
      logic [1:0][7:0] state_vec;
      logic [NUM_EVENTS-1:0] irq_stat;
      logic [NUM_EVENTS-1:0] irq_mask;
      logic [31:0] rdata;
      logic reset_pulse;
   } wdc_state_s;

   wdc_state_s s_r;
   wdc_state_s s_nxt;
   logic tick_fast;
   logic tick_slow;
   logic [1:0] tick;

   wdc_tick_gen #(
      .FAST_CYC(FAST_CYC),
      .SLOW_DIV(SLOW_PER_FAST)
   ) wdc_tick_gen_i (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .tick_fast(tick_fast),
      .tick_slow(tick_slow)
   );

   assign tick = {tick_slow, tick_fast}; // RL16

   function automatic logic [15:0] wdc_period(input logic [15:0] p, input logic idx);
      logic [15:0] dflt;
      dflt = idx ? DEFAULT_FINAL_TICKS : DEFAULT_FIRST_TICKS;
      if (p == 16'h0000 || p == PERIOD_ALL_ONES) begin
         return dflt; // RL4 RL6
      end
      return p;
   endfunction : wdc_period

   function automatic logic [7:0] wdc_code(input wdc_mode_e m);
      case (m)
         WDC_RUNNING: return ST_RUNNING;
         WDC_NO_ACTION: return ST_COUNTING_NO_ACTION; // RL12
         WDC_STOPPED: return ST_STOPPED;
         default: return ST_STOPPED;
      endcase
   endfunction : wdc_code

   logic [1:0] ld;
   logic [1:0][15:0] ldv;
   logic [NUM_EVENTS-1:0] ev;
   logic sel_ok;
   logic tgt_ok;
   logic idx;
   logic tidx;
   logic set_serviced;
   logic [31:0] rd_val;

   always_comb begin
      s_nxt = s_r;
      ld = '0;
      ldv = '0;
      ev = '0;
      idx = 1'b0;
      tidx = 1'b0;
      set_serviced = 1'b0;
      rd_val = '0;
      s_nxt.reset_pulse = 1'b0;
      sel_ok = (s_r.sel == SEL_FIRST) || (s_r.sel == SEL_FINAL); // RL1
      tgt_ok = (s_r.chain_target <= SEL_FINAL);

      // register writes and requests
      if (reg_wr) begin
         case (reg_addr)
            REG_SELECT: s_nxt.sel = reg_wdata[1:0];
            REG_PERIOD: s_nxt.period = reg_wdata[15:0]; // RL3
            REG_CHAIN_PERIOD: s_nxt.chain_period = reg_wdata[15:0];
            REG_CHAIN_TARGET: s_nxt.chain_target = reg_wdata[1:0];
            REG_ACTION_MASK: s_nxt.action_mask = reg_wdata[2:0]; // RL8
            REG_IRQ_MASK: s_nxt.irq_mask = reg_wdata[NUM_EVENTS-1:0];
            REG_IRQ_STATUS: begin
               s_nxt.irq_stat = s_r.irq_stat & ~reg_wdata[NUM_EVENTS-1:0];
               // host acknowledges the warning interrupt
               if (reg_wdata[EV_FIRST_EXPIRED] && s_r.irq_stat[EV_FIRST_EXPIRED] && s_r.expired) begin
                  set_serviced = 1'b1; // RL14
               end
            end
            REG_REQUEST: begin
               idx = (s_r.sel == SEL_FINAL);
               if (!sel_ok) begin
                  ev[EV_BAD_REQUEST] = 1'b1;
               end else if (reg_wdata[15:0] == START_REQUEST) begin // RL2
                  if (!tgt_ok) begin
                     ev[EV_BAD_REQUEST] = 1'b1;
                  end else begin
                     ld[idx] = 1'b1;
                     ldv[idx] = wdc_period(s_r.period, idx);
                     s_nxt.reload[idx] = ldv[idx];
                     s_nxt.chain_tgt[idx] = s_r.chain_target; // RL5
                     s_nxt.chain_per[idx] = s_r.chain_period;
                     if (s_r.mode[!idx] != WDC_STOPPED) begin
                        ld[!idx] = 1'b1; // RL17
                        ldv[!idx] = s_r.reload[!idx];
                     end
                  end
               end else if (reg_wdata[15:0] == INHIBIT_REQUEST) begin // RL2
                  for (int i = 0; i < 2; i++) begin
                     if (s_r.mode[i] != WDC_STOPPED) begin
                        s_nxt.mode[i] = s_r.action_mask[i] ? WDC_NO_ACTION : WDC_RUNNING; // RL7
                     end
                  end
                  // only the first stage may be halted
                  if (!idx && s_r.action_mask[FIRST_STAGE_MASK_BIT]) begin
                     s_nxt.mode[0] = WDC_STOPPED; // RL18
                  end
               end else if (reg_wdata[15:0] == STATUS_QUERY_REQUEST) begin // RL2
                  s_nxt.state_vec[0] = wdc_code(s_r.mode[0]) | (s_r.expired ? ST_EXPIRED : 8'h00)
                     | (s_r.serviced ? ST_SERVICED : 8'h00); // RL9 RL13
                  s_nxt.state_vec[1] = wdc_code(s_r.mode[1]); // RL9
                  s_nxt.serviced = 1'b0; // RL14 RL15
                  if (!idx) begin
                     s_nxt.expired = 1'b0;
                  end
               end else begin
                  ev[EV_BAD_REQUEST] = 1'b1;
               end
            end
            default: ;
         endcase
      end

      // countdown and expiry
      for (int i = 0; i < 2; i++) begin
         if (!ld[i] && s_r.mode[i] != WDC_STOPPED && tick[i]) begin
            if (s_r.cnt[i] > 16'h0001) begin
               s_nxt.cnt[i] = s_r.cnt[i] - 16'h0001;
            end else begin
               s_nxt.cnt[i] = '0;
               ev[i] = 1'b1;
               if (s_r.mode[i] == WDC_RUNNING) begin // RL11
                  if (i == 0) begin
                     s_nxt.expired = 1'b1; // RL13
                  end else begin
                     s_nxt.reset_pulse = 1'b1;
                  end
               end
               s_nxt.mode[i] = WDC_STOPPED;
               if (s_r.chain_tgt[i] != SEL_NONE) begin
                  tidx = (s_r.chain_tgt[i] == SEL_FINAL);
                  ld[tidx] = 1'b1; // RL5
                  ldv[tidx] = wdc_period(s_r.chain_per[i], tidx); // RL6
                  s_nxt.reload[tidx] = ldv[tidx];
               end
            end
         end
      end

      // starts and restarts
      for (int i = 0; i < 2; i++) begin
         if (ld[i]) begin
            s_nxt.cnt[i] = ldv[i];
            s_nxt.mode[i] = s_r.action_mask[i] ? WDC_NO_ACTION : WDC_RUNNING; // RL7 RL10
         end
      end

      // sticky flags: setting wins over clearing
      if (set_serviced) begin
         s_nxt.serviced = 1'b1; // RL14
      end
      s_nxt.irq_stat = s_nxt.irq_stat | ev;

      // read data, valid only in the cycle after the strobe
      if (reg_rd) begin
         case (reg_addr)
            REG_SELECT: rd_val = {30'h0, s_r.sel};
            REG_PERIOD: rd_val = {16'h0, s_r.period};
            REG_CHAIN_PERIOD: rd_val = {16'h0, s_r.chain_period};
            REG_CHAIN_TARGET: rd_val = {30'h0, s_r.chain_target};
            REG_ACTION_MASK: rd_val = {29'h0, s_r.action_mask};
            REG_STATE_VECTOR: rd_val = {16'h0, s_r.state_vec};
            REG_IRQ_STATUS: rd_val = {29'h0, s_r.irq_stat};
            REG_IRQ_MASK: rd_val = {29'h0, s_r.irq_mask};
            default: rd_val = '0;
         endcase
      end
      s_nxt.rdata = rd_val;
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         s_r <= '0; // RL19
         s_r.state_vec <= {ST_STOPPED, ST_STOPPED};
      end else begin
         s_r <= s_nxt;
      end
   end

   assign reg_rdata = s_r.rdata;
   assign warn_irq = s_r.expired;
   assign host_reset = s_r.reset_pulse;
   assign irq = |(s_r.irq_stat & s_r.irq_mask);
endmodule : wdc_watchdog

/* tb/wdc_host_model.sv */
// host software model issuing register accesses and requests
`timescale 1ns/1ps
module wdc_host_model (
   // clock
   input wire logic sys_clk,
   // register port
   output logic [7:0] reg_addr,
   output logic [31:0] reg_wdata,
   output logic reg_wr,
   output logic reg_rd,
   input wire logic [31:0] reg_rdata
);
   import wdc_pkg::*;
   initial begin
      reg_addr = 8'h0;
      reg_wdata = 32'h0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
   end
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
      // released data does not keep showing the last value
      reg_wdata <= ~d;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      @(posedge sys_clk);
      d = reg_rdata;
   endtask : rd
   task automatic req(input logic [1:0] sel, input logic [15:0] per, input logic [15:0] code);
      wr(REG_SELECT, {30'h0, sel});
      wr(REG_PERIOD, {16'h0, per});
      wr(REG_REQUEST, {16'h0, code});
   endtask : req
endmodule : wdc_host_model

/* tb/wdc_watchdog_asserts.sv */
// port-level checks for the watchdog control block
`timescale 1ns/1ps
module wdc_watchdog_asserts #(
   parameter int unsigned FAST_CYC = 10
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic resetn,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_rdata,
   // actions
   input wire logic warn_irq,
   input wire logic host_reset,
   input wire logic irq
);
   import wdc_pkg::*;
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!resetn);
   property p_rd_idle;
      !$past(reg_rd) |-> reg_rdata == 32'h0;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
   property p_req_rd;
      reg_rd && reg_addr == REG_REQUEST |=> reg_rdata == 32'h0;
   endproperty
   a_req_rd: assert property (p_req_rd) else $error("request reg not zero");
   property p_first_excl;
      reg_rd && reg_addr == REG_STATE_VECTOR |=> $onehot({reg_rdata[3], reg_rdata[2], reg_rdata[0]});
   endproperty
   a_first_excl: assert property (p_first_excl) else $error("first state not exclusive");
   property p_final_sv;
      reg_rd && reg_addr == REG_STATE_VECTOR |=> reg_rdata[15:8] inside {8'h01, 8'h04, 8'h08} && !reg_rdata[31:16];
   endproperty
   a_final_sv: assert property (p_final_sv) else $error("final state code bad");
   property p_mask_rb;
      reg_wr && reg_addr == REG_ACTION_MASK ##2 reg_rd && reg_addr == REG_ACTION_MASK
         |=> reg_rdata == {29'h0, $past(reg_wdata[2:0], 3)};
   endproperty
   a_mask_rb: assert property (p_mask_rb) else $error("mask readback");
   property p_rst_pulse;
      host_reset |=> !host_reset;
   endproperty
   a_rst_pulse: assert property (p_rst_pulse) else $error("host reset too long");
   property p_rst_gap;
      host_reset |=> !host_reset [*8];
   endproperty
   a_rst_gap: assert property (p_rst_gap) else $error("host reset pulses too close");
   property p_warn_hold;
      warn_irq && !(reg_wr && reg_addr == REG_REQUEST) |=> warn_irq;
   endproperty
   a_warn_hold: assert property (p_warn_hold) else $error("expired flag lost");
   property p_irq_off;
      reg_wr && reg_addr == REG_IRQ_MASK && reg_wdata[2:0] == 3'h0 |=> !irq;
   endproperty
   a_irq_off: assert property (p_irq_off) else $error("irq while masked");
endmodule : wdc_watchdog_asserts
bind wdc_watchdog wdc_watchdog_asserts #(.FAST_CYC(FAST_CYC)) wdc_watchdog_asserts_i (.sys_clk(sys_clk),
   .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .warn_irq(warn_irq), .host_reset(host_reset), .irq(irq));

/* tb/tb_two_stage_watchdog_control.sv */
// self-checking bench for the two-stage watchdog control block
`timescale 1ns/1ps
module tb_two_stage_watchdog_control;
   import wdc_pkg::*;
   logic sys_clk, resetn, reg_wr, reg_rd, warn_irq, host_reset, irq;
   logic [7:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata;
   int errors = 0;
   int n_checks = 0;
   wdc_watchdog #(.FAST_CYC(10)) wdc_watchdog_i (.sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .warn_irq(warn_irq),
      .host_reset(host_reset), .irq(irq));
   wdc_host_model wdc_host_model_i (.sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end
   task automatic close_out;
      $display("checks %0d mismatches %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : close_out
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] v;
      wdc_host_model_i.rd(a, v);
      chk($sformatf("reg %h", a), e, v);
   endtask : rdc
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      wdc_host_model_i.wr(a, d);
   endtask : wr
   task automatic sv(input logic [7:0] fin, input logic [7:0] fst);
      wr(REG_REQUEST, {16'h0, STATUS_QUERY_REQUEST});
      rdc(REG_STATE_VECTOR, {16'h0, fin, fst});
   endtask : sv
   task automatic wait_on(input bit fin, output int n);
      n = 0;
      while (n < 2000 && (fin ? host_reset : warn_irq) !== 1'b1) begin
         @(posedge sys_clk);
         n++;
      end
   endtask : wait_on
   task automatic t_reset;
      rdc(REG_STATE_VECTOR, {16'h0, ST_STOPPED, ST_STOPPED});
      rdc(REG_ACTION_MASK, 32'h0);
      wr(REG_ACTION_MASK, 32'h5);
      rdc(REG_ACTION_MASK, 32'h5);
      wr(REG_ACTION_MASK, 32'h0);
      rdc(8'hfc, 32'h0);
      rdc(REG_REQUEST, 32'h0);
      $display("test reset done");
   endtask : t_reset
   task automatic t_first;
      int n;
      wr(REG_IRQ_MASK, 32'h7);
      wdc_host_model_i.req(SEL_FIRST, 16'h3, START_REQUEST);
      wait_on(1'b0, n);
      chk("first expiry window", 32'h1, {31'h0, n >= 20 && n <= 40});
      chk("irq", 32'h1, {31'h0, irq});
      wr(REG_IRQ_STATUS, 32'h1);
      @(posedge sys_clk);
      chk("irq cleared", 32'h0, {31'h0, irq});
      sv(ST_STOPPED, ST_STOPPED | ST_EXPIRED | ST_SERVICED);
      chk("warn cleared", 32'h0, {31'h0, warn_irq});
      sv(ST_STOPPED, ST_STOPPED);
      $display("test first done");
   endtask : t_first
   task automatic t_final;
      int n;
      time t0;
      wr(REG_ACTION_MASK, 32'h2);
      wdc_host_model_i.req(SEL_FINAL, 16'h0, START_REQUEST);
      t0 = $time;
      sv(ST_COUNTING_NO_ACTION, ST_STOPPED);
      wr(REG_ACTION_MASK, 32'h0);
      wr(REG_REQUEST, {16'h0, INHIBIT_REQUEST});
      sv(ST_RUNNING, ST_STOPPED);
      wait_on(1'b1, n);
      n = int'(($time - t0) / 100);
      chk("final expiry window", 32'h1, {31'h0, n >= 1390 && n <= 1510});
      wr(REG_IRQ_STATUS, 32'h7);
      $display("test final done");
   endtask : t_final
   task automatic t_chain;
      int n;
      wr(REG_CHAIN_TARGET, 32'h2);
      wr(REG_CHAIN_PERIOD, 32'hffff);
      wdc_host_model_i.req(SEL_FIRST, 16'h2, START_REQUEST);
      wait_on(1'b0, n);
      sv(ST_RUNNING, ST_STOPPED | ST_EXPIRED);
      wr(REG_CHAIN_TARGET, 32'h0);
      wr(REG_IRQ_STATUS, 32'h7);
      $display("test chain done");
   endtask : t_chain
   task automatic t_bad;
      wdc_host_model_i.req(2'h3, 16'h1, START_REQUEST);
      rdc(REG_IRQ_STATUS, 32'h4);
      wr(REG_IRQ_STATUS, 32'h7);
      wr(REG_SELECT, 32'h1);
      wr(REG_REQUEST, {16'h0, REQ_BASE | 16'h3});
      rdc(REG_IRQ_STATUS, 32'h4);
      wr(REG_IRQ_STATUS, 32'h7);
      // chain target 3 refuses the start, chained final keeps running
      wr(REG_CHAIN_TARGET, 32'h3);
      wr(REG_REQUEST, {16'h0, START_REQUEST});
      rdc(REG_IRQ_STATUS, 32'h4);
      sv(ST_RUNNING, ST_STOPPED);
      wr(REG_CHAIN_TARGET, 32'h0);
      wr(REG_IRQ_STATUS, 32'h7);
      $display("test bad done");
   endtask : t_bad
   task automatic t_stop;
      wdc_host_model_i.req(SEL_FINAL, 16'd200, START_REQUEST);
      wdc_host_model_i.req(SEL_FIRST, 16'd50, START_REQUEST);
      wr(REG_ACTION_MASK, 32'h3);
      wr(REG_REQUEST, {16'h0, INHIBIT_REQUEST});
      sv(ST_COUNTING_NO_ACTION, ST_STOPPED);
      wr(REG_IRQ_MASK, 32'h0);
      $display("test stop done");
   endtask : t_stop
   task automatic t_rerst;
      // reset in mid-run, with the final stage counting and the action mask set
      @(posedge sys_clk);
      resetn <= 1'b0;
      repeat (2) @(posedge sys_clk);
      resetn <= 1'b1;
      chk("warn after reset", 32'h0, {31'h0, warn_irq});
      rdc(REG_ACTION_MASK, 32'h0);
      rdc(REG_STATE_VECTOR, {16'h0, ST_STOPPED, ST_STOPPED});
      rdc(REG_PERIOD, 32'h0);
      $display("test rerst done");
   endtask : t_rerst
   initial begin
      resetn = 1'b0;
      repeat (20) @(posedge sys_clk);
      resetn <= 1'b1;
      t_reset;
      t_first;
      t_final;
      t_chain;
      t_bad;
      t_stop;
      t_rerst;
      close_out;
   end
   initial begin
      #1_000_000;
      errors++;
      close_out;
   end
endmodule : tb_two_stage_watchdog_control
